/* gpm_defs.svh */
// Address map, reset values and pin positions of the muxed port
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH

// Register offsets
`define GPM_OFS_PIN     8'h00
`define GPM_OFS_LAT     8'h01
`define GPM_OFS_DIR     8'h02
`define GPM_OFS_SHARED  8'h03
`define GPM_OFS_WDT     8'h04

// Reset values
`define GPM_RST_LAT     8'h00
`define GPM_RST_DIR     8'hFF
`define GPM_RST_ANA     8'h00
`define GPM_RST_WDT     8'h00
`define GPM_RST_SHD     8'h00
`define GPM_RD_ZERO     8'h00

// Watchdog control bit that opens the shared address
`define GPM_WDT_SHR_BIT 4

// Analog-capable pins 7..4, config bits 7..4
`define GPM_ANA_LSB     4
`define GPM_ANA_MSB     7

// Pins owned by the memory interface: 3..0
`define GPM_EMI_MSB     3'h3

// Parallel port and relocated pwm pin positions
`define GPM_PIN_PD7     3'h2
`define GPM_PIN_PD6     3'h3
`define GPM_PIN_PD3     3'h4
`define GPM_PIN_BE      3'h5
`define GPM_PIN_RD      3'h6
`define GPM_PIN_P3C     3'h4
`define GPM_PIN_P3B     3'h5
`define GPM_PIN_P1C     3'h6

`endif

/* gpm_pin_model.sv */
// Outside circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_model (
	// Port side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// Level applied from outside
	input  wire logic [7:0] ext_level,
	output var  logic [7:0] pin_in
);
	// Outside drives only where the port lets go, so no contention
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

/* gpm_pkg.sv */
// Types shared by the muxed port and its users
package gpm_pkg;

	// Who drives a pin this cycle
	typedef enum logic [1:0] {
		OWN_PORT,
		OWN_EMI,
		OWN_PMP,
		OWN_PWM
	} gpm_owner_e;

	// Parallel master port signals toward the pins
	typedef struct packed {
		logic [2:0] dout;    // {bit7, bit6, bit3}
		logic       dout_en; // data lanes drive
		logic       be;      // byte enable
		logic       rd_out;  // read strobe value
		logic       rd_oe;   // read strobe drives
	} gpm_pmp_out_s;

	// Parallel master port signals from the pins
	typedef struct packed {
		logic [2:0] din;     // {bit7, bit6, bit3}
		logic       rd_in;   // read strobe in
	} gpm_pmp_in_s;

	// Pwm channels that may be relocated
	typedef struct packed {
		logic p3c;
		logic p3b;
		logic p1c;
		logic shutdown;      // shutdown event active
		logic tri_on_shut;   // float pins in shutdown
	} gpm_pwm_s;

	typedef logic [7:0] gpm_byte_t;

endpackage

/* gpm_port.sv */
// Eight-bit general purpose port with alternate function mux
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.svh"

// Notes on behaviour
// - Eight pins, output latch, readable state
// - Each pin has own direction bit
// - Memory interface drives low four pins
// - Pins 0..3 carry address 16..19
// - Memory interface ignores direction, forces output
// - Pins 4..7 analog or digital per bit
// - Analog at reset, output driver undisturbed
// - Parallel data 7,6,3 on pins 2,3,4
// - Parallel byte enable on pin 5
// - Parallel read strobe pin 6, both ways
// - Relocate pwm channels when config cleared
// - Pwm wins over latch, needs direction 0
// - Pwm pins may float during shutdown
// - Pins 4..6 feed comparator inputs
// - Port exists only on large package
// - Shared address shows analog config when open
module gpm_port
	import gpm_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output var  logic [7:0]   reg_rdata,
	// Port pins
	input  wire logic [7:0]   pin_in,
	output var  logic [7:0]   pin_out,
	output var  logic [7:0]   pin_oe,
	// External memory interface
	input  wire logic         ext_mem_en,
	input  wire logic [3:0]   ext_addr_hi,
	// Parallel master port
	input  wire logic         parallel_port_mux_sel,
	input  wire gpm_pmp_out_s pmp_out,
	output var  gpm_pmp_in_s  pmp_in,
	// Enhanced pwm channels
	input  wire logic         pwm_channel_relocate_cfg,
	input  wire gpm_pwm_s     pwm,
	// Analog routing, pins 7..4
	output var  logic [3:0]   analog_sel
);

	// Pin owner by priority: memory, pwm, parallel, latch
	// Later tests override earlier ones, so the last match wins
	// Pins outside every alternate range stay with the latch
	function automatic gpm_owner_e owner_of(
		input logic [2:0] idx,
		input logic       emi,
		input logic       pmp_on,
		input logic       pwm_on
	);
		logic is_pmp;
		logic is_pwm;
		is_pmp = (idx >= `GPM_PIN_PD7) && (idx <= `GPM_PIN_RD);
		is_pwm = (idx >= `GPM_PIN_P3C) && (idx <= `GPM_PIN_P1C);
		owner_of = OWN_PORT;
		if (pmp_on && is_pmp) begin
			owner_of = OWN_PMP;
		end
		if (pwm_on && is_pwm) begin
			owner_of = OWN_PWM;
		end
		if (emi && (idx <= `GPM_EMI_MSB)) begin
			owner_of = OWN_EMI;
		end
	endfunction

	// Software-visible state
	gpm_byte_t lat_reg;
	gpm_byte_t lat_next;
	gpm_byte_t dir_reg;
	gpm_byte_t dir_next;
	gpm_byte_t ana_reg;
	gpm_byte_t ana_next;
	gpm_byte_t wdt_reg;
	gpm_byte_t wdt_next;
	gpm_byte_t shd_reg;
	gpm_byte_t shd_next;

	// Pin synchronisers
	gpm_byte_t sync1_reg;
	gpm_byte_t sync2_reg;

	// Output flops
	gpm_byte_t   rdata_reg;
	gpm_byte_t   rdata_next;
	gpm_byte_t   pout_reg;
	gpm_byte_t   pout_next;
	gpm_byte_t   poe_reg;
	gpm_byte_t   poe_next;
	gpm_pmp_in_s pin_reg;
	gpm_pmp_in_s pin_next;
	logic [3:0]  asel_reg;
	logic [3:0]  asel_next;

	// Address decode
	wire logic hit_pin    = (reg_addr == `GPM_OFS_PIN);
	wire logic hit_lat    = (reg_addr == `GPM_OFS_LAT);
	wire logic hit_dir    = (reg_addr == `GPM_OFS_DIR);
	wire logic hit_shared = (reg_addr == `GPM_OFS_SHARED);
	wire logic hit_wdt    = (reg_addr == `GPM_OFS_WDT);

	// Shared address steering
	// A write while the window is closed lands in the default byte
	wire logic shared_open = wdt_reg[`GPM_WDT_SHR_BIT];
	wire logic wr_ana      = reg_wr && hit_shared && shared_open;
	wire logic wr_shd      = reg_wr && hit_shared && !shared_open;

	// Writing the pin address also loads the latch
	wire logic wr_lat = reg_wr && (hit_lat || hit_pin);
	wire logic wr_dir = reg_wr && hit_dir;
	wire logic wr_wdt = reg_wr && hit_wdt;

	// Register next values
	assign lat_next = wr_lat ? reg_wdata : lat_reg;
	assign dir_next = wr_dir ? reg_wdata : dir_reg;
	assign ana_next = wr_ana ? reg_wdata : ana_reg;
	assign shd_next = wr_shd ? reg_wdata : shd_reg;
	assign wdt_next = wr_wdt ? reg_wdata : wdt_reg;

	// Cleared config bit selects analog on pins 7..4
	wire logic [3:0] ana_pins = ~ana_reg[`GPM_ANA_MSB:`GPM_ANA_LSB];
	// Pins 3..0 are digital only, so always readable
	wire gpm_byte_t  dig_mask = {~ana_pins, 4'hF};

	// Pin state read; analog pins read low
	wire gpm_byte_t pin_state = LARGE_PACKAGE ? (sync2_reg & dig_mask) : `GPM_RD_ZERO;

	// Read data mux; unmapped addresses read zero
	wire gpm_byte_t shared_rd = shared_open ? ana_reg : shd_reg;
	wire gpm_byte_t lat_rd    = LARGE_PACKAGE ? lat_reg : `GPM_RD_ZERO;
	wire gpm_byte_t dir_rd    = LARGE_PACKAGE ? dir_reg : `GPM_RD_ZERO;
	assign rdata_next = !reg_rd    ? `GPM_RD_ZERO :
	                    hit_pin    ? pin_state    :
	                    hit_lat    ? lat_rd       :
	                    hit_dir    ? dir_rd       :
	                    hit_shared ? shared_rd    :
	                    hit_wdt    ? wdt_reg      :
	                    `GPM_RD_ZERO;

	// Pwm channels move here only when config bit is low
	wire logic pwm_here = !pwm_channel_relocate_cfg;
	// Parallel port owns its pins only with mux select 0
	wire logic pmp_here = !parallel_port_mux_sel;

	// Float relocated pwm pins in shutdown when asked
	wire logic pwm_float = pwm.shutdown && pwm.tri_on_shut;

	// Alternate function values laid out by pin
	// Address bit 16 lands on pin 0, bit 19 on pin 3
	wire gpm_byte_t emi_val = {4'h0, ext_addr_hi};
	wire gpm_byte_t pwm_val = {1'b0, pwm.p1c, pwm.p3b, pwm.p3c, 4'h0};
	// Data bit 7 on pin 2, bit 6 on pin 3, bit 3 on pin 4
	wire gpm_byte_t pmp_val = {1'b0, pmp_out.rd_out, pmp_out.be,
	                           pmp_out.dout[0], pmp_out.dout[1], pmp_out.dout[2], 2'b00};
	wire gpm_byte_t pmp_oen = {1'b0, pmp_out.rd_oe, 1'b1, {3{pmp_out.dout_en}}, 2'b00};

	// Per-pin driver selection
	for (genvar i = 0; i < 8; i++) begin : g_pin
		wire gpm_owner_e own = owner_of(3'(i), ext_mem_en, pmp_here, pwm_here);
		// Own variables per pin keep each process the sole writer
		logic out_bit;
		logic oe_bit;
		always_comb begin
			unique case (own)
				// Memory address beats all other drivers
				OWN_EMI: begin
					out_bit = emi_val[i];
					oe_bit  = 1'b1;
				end
				// Pwm wins, only with direction 0
				OWN_PWM: begin
					out_bit = pwm_val[i];
					oe_bit  = !dir_reg[i] && !pwm_float;
				end
				// Parallel port drives its own enables
				OWN_PMP: begin
					out_bit = pmp_val[i];
					oe_bit  = pmp_oen[i];
				end
				// Ordinary port pin follows its direction bit
				OWN_PORT: begin
					out_bit = lat_reg[i];
					oe_bit  = !dir_reg[i];
				end
			endcase
		end
		assign pout_next[i] = out_bit;
		assign poe_next[i]  = oe_bit;
	end

	// Pin order of address bits is 16..19 on pins 0..3
	// Analog select leaves the driver above untouched

	// Read strobe and data are also taken back in
	assign pin_next.din   = {sync2_reg[`GPM_PIN_PD7],
	                         sync2_reg[`GPM_PIN_PD6],
	                         sync2_reg[`GPM_PIN_PD3] & dig_mask[`GPM_PIN_PD3]};
	assign pin_next.rd_in = sync2_reg[`GPM_PIN_RD] & dig_mask[`GPM_PIN_RD];

	// Analog pins 4..6 reach comparators, 4..7 the converter
	assign asel_next = LARGE_PACKAGE ? ana_pins : 4'h0;

	// Software registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lat_reg <= `GPM_RST_LAT;
			dir_reg <= `GPM_RST_DIR;
			ana_reg <= `GPM_RST_ANA;
			wdt_reg <= `GPM_RST_WDT;
			shd_reg <= `GPM_RST_SHD;
		end else begin
			lat_reg <= lat_next;
			dir_reg <= dir_next;
			ana_reg <= ana_next;
			wdt_reg <= wdt_next;
			shd_reg <= shd_next;
		end
	end

	// Two-flop synchroniser; first stage feeds only the second
	// Pin levels are asynchronous; one flop alone could go metastable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Registered outputs; small package keeps every pin floating
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg <= `GPM_RD_ZERO;
			pout_reg  <= 8'h00;
			poe_reg   <= 8'h00;
			pin_reg   <= '0;
			asel_reg  <= 4'hF;
		end else begin
			rdata_reg <= rdata_next;
			pout_reg  <= pout_next;
			// No driver without the large package
			poe_reg   <= LARGE_PACKAGE ? poe_next : 8'h00;
			pin_reg   <= pin_next;
			asel_reg  <= asel_next;
		end
	end

	// Output assignments
	assign reg_rdata  = rdata_reg;
	assign pin_out    = pout_reg;
	assign pin_oe     = poe_reg;
	assign pmp_in     = pin_reg;
	assign analog_sel = asel_reg;

endmodule

`default_nettype wire

/* gpm_port_properties.sv */
// Port-level properties of the muxed port
`timescale 1ns/1ps
`default_nettype none
module gpm_port_properties
	import gpm_pkg::*;
(
	// Clock, reset and bus
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire logic         reg_rd,
	input wire logic [7:0]   reg_rdata,
	// Pins and mux controls
	input wire logic [7:0]   pin_out,
	input wire logic [7:0]   pin_oe,
	input wire logic         ext_mem_en,
	input wire logic [3:0]   ext_addr_hi,
	input wire logic         parallel_port_mux_sel,
	input wire gpm_pmp_out_s pmp_out,
	input wire logic         pwm_channel_relocate_cfg,
	input wire gpm_pwm_s     pwm,
	input wire logic [3:0]   analog_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Parallel port owns pins 2..6 only while pwm stays home
	sequence s_pmp_owns;
		!parallel_port_mux_sel && pwm_channel_relocate_cfg;
	endsequence
	sequence s_pwm_moved;
		!pwm_channel_relocate_cfg;
	endsequence
	// Reset check must run while reset is high, so no disable
	a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
		pin_oe == 8'h00 && analog_sel == 4'hF && reg_rdata == 8'h00) else $error("reset state");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data left standing");
	a_emi_addr: assert property (ext_mem_en |=>
		pin_oe[3:0] == 4'hF && pin_out[3:0] == $past(ext_addr_hi)) else $error("address pins");
	a_pmp_data: assert property (s_pmp_owns ##0 (!ext_mem_en && pmp_out.dout_en) |=> pin_oe[4:2] == 3'h7 &&
		pin_out[4:2] == {$past(pmp_out.dout[0]), $past(pmp_out.dout[1]), $past(pmp_out.dout[2])}) else $error("data lanes");
	a_pmp_bytee: assert property (s_pmp_owns |=> pin_oe[5] && pin_out[5] == $past(pmp_out.be))
		else $error("byte enable pin");
	a_pmp_strobe: assert property (s_pmp_owns ##0 pmp_out.rd_oe |=>
		pin_oe[6] && pin_out[6] == $past(pmp_out.rd_out)) else $error("read strobe pin");
	a_pwm_float: assert property (s_pwm_moved ##0 (pwm.shutdown && pwm.tri_on_shut) |=> pin_oe[6:4] == 3'h0)
		else $error("pwm pins not floated");
	a_pwm_wins: assert property (s_pwm_moved ##0 !(pwm.shutdown && pwm.tri_on_shut) |=>
		(pin_oe[6:4] & (pin_out[6:4] ^ {$past(pwm.p1c), $past(pwm.p3b), $past(pwm.p3c)})) == 3'h0)
		else $error("pwm pin value");
endmodule
`default_nettype wire

/* gpm_port_tb.sv */
// Self-checking bench for the muxed port
`timescale 1ns/1ps
`default_nettype none
module gpm_port_tb;
	import gpm_pkg::*;
	logic         clk, sys_rst, reg_wr, reg_rd, rd_d, ext_mem_en, parallel_port_mux_sel, pwm_channel_relocate_cfg;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, ext_level, lat, v;
	logic [3:0]   ext_addr_hi, analog_sel;
	gpm_pmp_out_s pmp_out;
	gpm_pmp_in_s  pmp_in;
	gpm_pwm_s     pwm;
	logic [7:0]   exp_q[$];
	int           num_errors, cmp_count;
	gpm_port uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_mem_en(ext_mem_en), .ext_addr_hi(ext_addr_hi), .parallel_port_mux_sel(parallel_port_mux_sel),
		.pmp_out(pmp_out), .pmp_in(pmp_in), .pwm_channel_relocate_cfg(pwm_channel_relocate_cfg), .pwm(pwm),
		.analog_sel(analog_sel));
	gpm_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic test_done;
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Read data stand only one cycle; sample mid-cycle to avoid edge races
	always @(posedge clk)
		rd_d <= reg_rd;
	always @(negedge clk)
		if (rd_d && exp_q.size() > 0)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		{reg_wr, reg_rd, ext_mem_en, sys_rst} = 4'h1;
		{parallel_port_mux_sel, pwm_channel_relocate_cfg} = 2'h3;
		{reg_addr, reg_wdata, ext_addr_hi} = '0;
		pmp_out = '0;
		pwm = '0;
		ext_level = 8'hA5;
		void'($urandom(32'hd1fc));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h01, 8'h00);
		rd(8'h02, 8'hFF);
		rd(8'h03, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h00, 8'h05);
		// Open shared address, make pins 7..4 digital, close it
		wr(8'h04, 8'h10);
		wr(8'h03, 8'hF0);
		rd(8'h03, 8'hF0);
		chk("analog_sel", 8'h00, {4'h0, analog_sel});
		wr(8'h04, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h00, 8'hA5);
		// Outputs loop back through the pins
		lat = 8'($urandom());
		wr(8'h01, lat);
		wr(8'h02, 8'h00);
		repeat (5) @(posedge clk);
		rd(8'h00, lat);
		// Memory interface forces pins 3..0 out despite direction
		v = 8'($urandom());
		ext_mem_en  <= 1'b1;
		ext_addr_hi <= v[3:0];
		wr(8'h02, 8'hFF);
		repeat (5) @(posedge clk);
		rd(8'h00, {4'hA, v[3:0]});
		// Random mux traffic; the checker judges the pins
		wr(8'h02, 8'h00);
		repeat (80) begin
			@(posedge clk);
			{ext_mem_en, parallel_port_mux_sel, pwm_channel_relocate_cfg} <= 3'($urandom());
			ext_addr_hi <= 4'($urandom());
			pmp_out     <= 7'($urandom());
			pwm         <= 5'($urandom());
		end
		// Parallel port samples pins 2..4 and 6 as inputs
		@(posedge clk);
		{ext_mem_en, parallel_port_mux_sel, pwm_channel_relocate_cfg} <= 3'h1;
		pmp_out   <= '0;
		ext_level <= 8'($urandom());
		wr(8'h02, 8'hFF);
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("pmp_in", {4'h0, ext_level[2], ext_level[3], ext_level[4], ext_level[6]}, 8'(pmp_in));
		repeat (3) @(posedge clk);
		test_done();
	end
endmodule
bind gpm_port gpm_port_properties props (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pin_out(pin_out), .pin_oe(pin_oe), .ext_mem_en(ext_mem_en), .ext_addr_hi(ext_addr_hi),
	.parallel_port_mux_sel(parallel_port_mux_sel), .pmp_out(pmp_out),
	.pwm_channel_relocate_cfg(pwm_channel_relocate_cfg), .pwm(pwm), .analog_sel(analog_sel));
`default_nettype wire
